//--- logic/dcp_cke_power.sv
// module: clock-enable power-state control of the dram (top)
// ***********************************************
// What this block does
// RULE_01: transitions use clock-enable at previous and current edge, state before edge.
// RULE_02: controller drops clock-enable only after mode set and update delays.
// RULE_03: clock-enable level held until one cycle before its minimum pulse.
// RULE_04: power-down entry and exit only with no-operation or deselect.
// RULE_05: self refresh exits on clock-enable rise with no-operation or deselect.
// RULE_06: banks active plus clock-enable fall with nop enters active power-down.
// RULE_07: fall during read, write, precharge picks power-down by banks at the end.
// RULE_08: fall while refreshing or all idle enters precharge power-down.
// RULE_09: self refresh entered only from idle with refresh on the falling edge.
// RULE_10: controller never requests self refresh during read or write.
// RULE_11: no internal refresh runs while in power-down.
// RULE_12: clock-enable low in low power ignores command and address inputs.
// RULE_13: controller waits exit delay and relock delay after self refresh.
// RULE_14: first write no sooner than 512 cycles after self refresh exit.
// RULE_15: termination never affects transitions and is off in self refresh.
// RULE_16: idle means banks closed, no burst, clock-enable high, timings met.
// RULE_17: any other combination needs a legal general command.
// RULE_18: deselect decodes like no-operation and ends no running operation.
// RULE_19: self refresh exit is seen without relying on internal clocking.
// RULE_20: power-down exit returns to bank-active or all-idle as before entry.
// ***********************************************
`timescale 1ns/100ps
module dcp_cke_power #(
  parameter int OP_CYCLES = dcp_pkg::DCP_OP_CYCLES
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst_b,
  // command pins
  input  wire logic              cke,
  input  wire logic              cs_b,
  input  wire logic              ras_b,
  input  wire logic              cas_b,
  input  wire logic              we_b,
  input  wire logic              a10,
  input  wire logic              odt,
  // status
  output logic [2:0]             power_state,
  output logic                   in_powerdown,
  output logic                   in_selfrefresh,
  output logic                   refresh_enable,
  output logic                   odt_enable,
  output logic                   device_idle,
  output logic                   exit_settled,
  output logic                   write_allowed
);
  import dcp_pkg::*;

  // ***********************************************
  // command decode
  // ***********************************************
  dcp_cmd_if cif ();

  dcp_cmd_decode u_dec (
    .clock (clock),
    .rst_b (rst_b),
    .cke   (cke),
    .cs_b  (cs_b),
    .ras_b (ras_b),
    .cas_b (cas_b),
    .we_b  (we_b),
    .a10   (a10),
    .out   (cif)
  );

  // odt is accepted but deliberately unused in the state logic
  wire odt_unused = odt; // see RULE_15

  // ***********************************************
  // state, open-bank flag and operation timer
  // ***********************************************
  dcp_state_t             state_r;
  dcp_state_t             state_nxt;
  logic                   banks_open_r;
  logic                   banks_open_nxt;
  logic [3:0]             op_cnt_r;
  logic [3:0]             op_cnt_nxt;
  // exit counters load only on a self refresh exit, so after reset writes are allowed
  logic [DCP_CNT_W-1:0]   srx_cnt_r;
  logic [DCP_CNT_W-1:0]   srx_cnt_nxt;
  logic [DCP_CNT_W-1:0]   wr_cnt_r;
  logic [DCP_CNT_W-1:0]   wr_cnt_nxt;

  wire fall     = cif.cke_prev && !cif.cke_cur;
  wire rise     = !cif.cke_prev && cif.cke_cur;
  wire stay_low = !cif.cke_prev && !cif.cke_cur;
  wire is_nop   = (cif.cmd == DCP_CMD_NOP);
  wire op_done  = (op_cnt_r == 4'h0);
  // idle also needs the exit delay counted down; clock-enable is judged before the edge,
  // since on the entry edge itself the current sample is already low
  wire idle_ok  = (state_r == DCP_IDLE) && !banks_open_r && cif.cke_prev
                  && (srx_cnt_r == '0); // see RULE_16

  localparam logic [3:0] OP_LOAD = 4'(OP_CYCLES);
  localparam logic [DCP_CNT_W-1:0] CNT_ONE = DCP_CNT_W'(1);

  // ***********************************************
  // transition decision
  // ***********************************************
  always_comb begin
    state_nxt      = state_r;
    banks_open_nxt = banks_open_r;
    op_cnt_nxt     = op_done ? op_cnt_r : op_cnt_r - 4'h1;
    srx_cnt_nxt    = (srx_cnt_r == '0) ? srx_cnt_r : srx_cnt_r - CNT_ONE;
    wr_cnt_nxt     = (wr_cnt_r == '0) ? wr_cnt_r : wr_cnt_r - CNT_ONE;
    case (state_r)
      DCP_PD_ACTIVE, DCP_PD_PRECHARGE: begin
        // commands ignored while clock-enable stays low
        if (stay_low) state_nxt = state_r; // see RULE_12
        else if (rise && is_nop) begin // see RULE_04
          state_nxt = (state_r == DCP_PD_ACTIVE) ? DCP_ACTIVE : DCP_IDLE; // see RULE_20
        end else if (rise) begin // see RULE_04
          // any other command on the exit edge is refused and the state kept
          state_nxt = state_r;
        end
      end
      DCP_SELF_REFRESH: begin
        // the rise is taken from the pin samples alone, no internal timing
        if (stay_low) state_nxt = state_r; // see RULE_12
        else if (rise && is_nop) begin // see RULE_05 RULE_19
          state_nxt   = DCP_IDLE;
          srx_cnt_nxt = DCP_CNT_W'(DCP_SRX_DELAY_CYC);
          wr_cnt_nxt  = DCP_CNT_W'(DCP_WRITE_HOLD_NCK);
        end else if (rise) begin // see RULE_05
          // any other command on the exit edge is refused and the state kept
          state_nxt = state_r;
        end
      end
      DCP_ACTIVE: begin
        if (fall && is_nop) state_nxt = DCP_PD_ACTIVE; // see RULE_06
        else if (!fall) begin
          if (cif.cmd == DCP_CMD_READ || cif.cmd == DCP_CMD_WRITE) begin
            state_nxt  = DCP_BUSY;
            op_cnt_nxt = OP_LOAD;
          end else if (cif.cmd == DCP_CMD_PRECHARGE) begin
            state_nxt      = DCP_BUSY;
            op_cnt_nxt     = OP_LOAD;
            banks_open_nxt = 1'b0;
          end
        end
      end
      DCP_BUSY: begin
        // a nop does not cut the running operation short
        // the op timer keeps running in power-down, so a late exit finds the command done
        if (fall && is_nop) begin // see RULE_07 RULE_18
          state_nxt = banks_open_r ? DCP_PD_ACTIVE : DCP_PD_PRECHARGE;
        end else if (op_done) begin
          state_nxt = banks_open_r ? DCP_ACTIVE : DCP_IDLE;
        end
      end
      DCP_REFRESHING: begin
        if (fall && is_nop) state_nxt = DCP_PD_PRECHARGE; // see RULE_08
        else if (op_done) state_nxt = DCP_IDLE;
      end
      default: begin
        if (fall && is_nop && idle_ok) state_nxt = DCP_PD_PRECHARGE; // see RULE_08
        else if (fall && cif.cmd == DCP_CMD_REFRESH && idle_ok) begin
          state_nxt = DCP_SELF_REFRESH; // see RULE_09
        end else if (!fall && cif.cmd == DCP_CMD_REFRESH) begin
          state_nxt  = DCP_REFRESHING;
          op_cnt_nxt = OP_LOAD;
        end else if (!fall && cif.cmd == DCP_CMD_ACTIVATE) begin
          state_nxt      = DCP_ACTIVE;
          banks_open_nxt = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_r      <= DCP_IDLE;
      banks_open_r <= 1'b0;
      op_cnt_r     <= 4'h0;
      srx_cnt_r    <= '0;
      wr_cnt_r     <= '0;
    end else begin
      state_r      <= state_nxt; // see RULE_01
      banks_open_r <= banks_open_nxt;
      op_cnt_r     <= op_cnt_nxt;
      srx_cnt_r    <= srx_cnt_nxt;
      wr_cnt_r     <= wr_cnt_nxt;
    end
  end

  // ***********************************************
  // registered status outputs
  // ***********************************************
  wire pd_nxt = (state_nxt == DCP_PD_ACTIVE) || (state_nxt == DCP_PD_PRECHARGE);
  wire sr_nxt = (state_nxt == DCP_SELF_REFRESH);
  // a refused fall leaves the state idle with clock-enable low, which is not idle
  wire idle_nxt    = (state_nxt == DCP_IDLE) && !banks_open_nxt && (srx_cnt_nxt == '0)
                     && cif.cke_cur; // see RULE_16
  wire settled_nxt = (srx_cnt_nxt == '0);
  wire wr_ok_nxt   = (wr_cnt_nxt == '0);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      power_state    <= 3'h0;
      in_powerdown   <= 1'b0;
      in_selfrefresh <= 1'b0;
      refresh_enable <= 1'b1;
      odt_enable     <= 1'b1;
      device_idle    <= 1'b0;
      exit_settled   <= 1'b1;
      write_allowed  <= 1'b1;
    end else begin
      power_state    <= 3'(state_nxt);
      in_powerdown   <= pd_nxt;
      in_selfrefresh <= sr_nxt;
      refresh_enable <= !pd_nxt;                 // see RULE_11
      odt_enable     <= !sr_nxt;                 // see RULE_15
      device_idle    <= idle_nxt;
      exit_settled   <= settled_nxt;
      write_allowed  <= wr_ok_nxt;
    end
  end

endmodule : dcp_cke_power

//--- logic/dcp_cmd_decode.sv
// module: synchronises the command pins and decodes the command at each edge
`timescale 1ns/100ps
module dcp_cmd_decode (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_b,
  // pins
  input  wire logic cke,
  input  wire logic cs_b,
  input  wire logic ras_b,
  input  wire logic cas_b,
  input  wire logic we_b,
  input  wire logic a10,
  // decoded output
  dcp_cmd_if.src    out
);
  import dcp_pkg::*;

  // ***********************************************
  // two-stage synchronisers
  // ***********************************************
  logic [5:0] s1_r;
  logic [5:0] s2_r;
  logic       cke_prev_r;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s1_r       <= 6'h00;
      s2_r       <= 6'h00;
      cke_prev_r <= 1'b0;
    end else begin
      s1_r       <= {cke, cs_b, ras_b, cas_b, we_b, a10};
      s2_r       <= s1_r;
      cke_prev_r <= s2_r[5];
    end
  end

  wire       cs_n_s  = s2_r[4];
  wire [2:0] rcw     = s2_r[3:1];
  // deselect decodes exactly as no-operation
  wire       is_nop  = cs_n_s || (rcw == 3'h7); // see RULE_18
  dcp_cmd_t  cmd_w;

  always_comb begin
    if (is_nop)              cmd_w = DCP_CMD_NOP;
    else if (rcw == 3'h1)    cmd_w = DCP_CMD_REFRESH;
    else if (rcw == 3'h3)    cmd_w = DCP_CMD_ACTIVATE;
    else if (rcw == 3'h2)    cmd_w = DCP_CMD_PRECHARGE;
    else if (rcw == 3'h5)    cmd_w = DCP_CMD_READ;
    else if (rcw == 3'h4)    cmd_w = DCP_CMD_WRITE;
    else                     cmd_w = DCP_CMD_OTHER;
  end

  assign out.cke_prev = cke_prev_r; // see RULE_01
  assign out.cke_cur  = s2_r[5];
  assign out.cmd      = cmd_w;

endmodule : dcp_cmd_decode

//--- logic/dcp_cmd_if.sv
// interface: decoded command and clock-enable samples passed to the state logic
`timescale 1ns/100ps
interface dcp_cmd_if;
  import dcp_pkg::*;
  logic     cke_prev;
  logic     cke_cur;
  dcp_cmd_t cmd;
  modport src (output cke_prev, output cke_cur, output cmd);
  modport dst (input cke_prev, input cke_cur, input cmd);
endinterface : dcp_cmd_if

//--- logic/dcp_pkg.sv
// package: power states, command codes and timing constants of the clock-enable power logic
package dcp_pkg;

  // ***********************************************
  // power and bank state
  // ***********************************************
  typedef enum logic [2:0] {
    DCP_IDLE,
    DCP_ACTIVE,
    DCP_BUSY,
    DCP_REFRESHING,
    DCP_PD_ACTIVE,
    DCP_PD_PRECHARGE,
    DCP_SELF_REFRESH
  } dcp_state_t;

  // decoded command at the edge
  typedef enum logic [2:0] {
    DCP_CMD_NOP,
    DCP_CMD_REFRESH,
    DCP_CMD_ACTIVATE,
    DCP_CMD_PRECHARGE,
    DCP_CMD_READ,
    DCP_CMD_WRITE,
    DCP_CMD_OTHER
  } dcp_cmd_t;

  // ***********************************************
  // timing
  // ***********************************************
  localparam int DCP_CLK_PERIOD_NS   = 100;
  localparam int DCP_CKE_SYNC_STAGES = 2;
  localparam int DCP_WRITE_HOLD_NCK  = 512;
  localparam int DCP_SRX_DELAY_NS    = 1000;
  localparam int DCP_SRX_DELAY_CYC   =
    (DCP_SRX_DELAY_NS + DCP_CLK_PERIOD_NS - 1) / DCP_CLK_PERIOD_NS;
  localparam int DCP_OP_CYCLES       = 4;
  localparam int DCP_CNT_W           = 10;

endpackage : dcp_pkg

//--- verif/dcp_cke_power_asserts.sv
// checker: power-state assertions for the clock-enable power block
`timescale 1ns/100ps
module dcp_cke_power_asserts
  import dcp_pkg::*;
(
  // clock and reset
  input wire logic       clock,
  input wire logic       rst_b,
  // pins
  input wire logic       cke,
  input wire logic       cs_b,
  input wire logic       ras_b,
  input wire logic       cas_b,
  input wire logic       we_b,
  // status
  input wire logic [2:0] power_state,
  input wire logic       in_powerdown,
  input wire logic       in_selfrefresh,
  input wire logic       refresh_enable,
  input wire logic       odt_enable,
  input wire logic       exit_settled,
  input wire logic       write_allowed
);
  // ******************
  // pipeline matching the two-stage sync
  // ******************
  logic c1, c2, c3, n1, n2, f1, f2;
  wire  nop_w  = cs_b | (ras_b & cas_b & we_b);
  wire  ref_w  = !cs_b && {ras_b, cas_b, we_b} == 3'h1;
  wire  fall_w = c3 & ~c2;
  wire  rise_w = ~c3 & c2;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) {c1, c2, c3, n1, n2, f1, f2} <= '0;
    else {c1, c2, c3, n1, n2, f1, f2} <= {cke, c1, c2, nop_w, n1, ref_w, f1};
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  property p_pd_pre;
    power_state == DCP_IDLE && fall_w && n2 |=> power_state == DCP_PD_PRECHARGE && in_powerdown;
  endproperty
  a_pd_pre: assert property (p_pd_pre) else $error("no precharge power-down");
  property p_pd_act;
    power_state == DCP_ACTIVE && fall_w && n2 |=> power_state == DCP_PD_ACTIVE;
  endproperty
  a_pd_act: assert property (p_pd_act) else $error("no active power-down");
  property p_sr_in;
    power_state == DCP_IDLE && fall_w && f2 |=> power_state == DCP_SELF_REFRESH && in_selfrefresh;
  endproperty
  a_sr_in: assert property (p_sr_in) else $error("no self refresh entry");
  property p_hold;
    (in_powerdown || in_selfrefresh) && !c2 && !c3 |=> $stable(power_state);
  endproperty
  a_hold: assert property (p_hold) else $error("low-power state left");
  property p_pd_out;
    in_powerdown && rise_w && n2 |=> !in_powerdown && power_state == {2'h0, $past(power_state) == 3'h4};
  endproperty
  a_pd_out: assert property (p_pd_out) else $error("bad power-down exit");
  property p_sr_out;
    in_selfrefresh && rise_w && n2 |=> power_state == DCP_IDLE && !exit_settled && !write_allowed;
  endproperty
  a_sr_out: assert property (p_sr_out) else $error("bad self refresh exit");
  property p_settle;
    $fell(exit_settled) |-> ##[9:11] $rose(exit_settled);
  endproperty
  a_settle: assert property (p_settle) else $error("exit delay wrong");
  property p_wr_hold;
    $fell(write_allowed) |-> ##[511:513] $rose(write_allowed);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write hold wrong");
  property p_odt;
    odt_enable != in_selfrefresh && in_selfrefresh == (power_state == DCP_SELF_REFRESH);
  endproperty
  a_odt: assert property (p_odt) else $error("termination in self refresh");
  property p_no_ref;
    in_powerdown |-> !refresh_enable && power_state inside {DCP_PD_ACTIVE, DCP_PD_PRECHARGE};
  endproperty
  a_no_ref: assert property (p_no_ref) else $error("refresh in power-down");
endmodule : dcp_cke_power_asserts

bind dcp_cke_power dcp_cke_power_asserts dcp_cke_power_asserts_inst (.clock, .rst_b, .cke,
  .cs_b, .ras_b, .cas_b, .we_b, .power_state, .in_powerdown, .in_selfrefresh,
  .refresh_enable, .odt_enable, .exit_settled, .write_allowed);

//--- verif/dcp_cke_power_tb_top.sv
// testbench: power-state scenarios driven through the controller model
`timescale 1ns/100ps
module dcp_cke_power_tb_top;
  import dcp_pkg::*;
  logic       clock = 0, rst_b = 0, odt = 0, cke_req = 0, des_req = 0;
  logic       cke, cs_b, ras_b, cas_b, we_b, a10, pd, sr, ref_en, odt_en, idle, settled, wr_ok;
  logic [4:0] junk = '0;
  logic [2:0] power_state;
  dcp_cmd_t   cmd_req = DCP_CMD_NOP;
  dcp_cmd_t   ops[2] = '{DCP_CMD_READ, DCP_CMD_WRITE};
  int         failures = 0, checks_done = 0, cycles = 0;
  always #50 clock = ~clock;
  always @(negedge clock) begin
    junk <= 5'($urandom);
    odt  <= 1'($urandom);
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      summarize();
    end
  end
  dcp_ctl_model dcp_ctl_model_inst (.clock(clock), .cke_req(cke_req), .cmd_req(cmd_req),
    .des_req(des_req), .junk(junk), .cke(cke), .cs_b(cs_b), .ras_b(ras_b), .cas_b(cas_b),
    .we_b(we_b), .a10(a10));
  dcp_cke_power dcp_cke_power_inst (.clock(clock), .rst_b(rst_b), .cke(cke), .cs_b(cs_b),
    .ras_b(ras_b), .cas_b(cas_b), .we_b(we_b), .a10(a10), .odt(odt), .power_state(power_state),
    .in_powerdown(pd), .in_selfrefresh(sr), .refresh_enable(ref_en), .odt_enable(odt_en),
    .device_idle(idle), .exit_settled(settled), .write_allowed(wr_ok));
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  function automatic dcp_state_t exit_of(dcp_state_t s);
    return (s == DCP_PD_ACTIVE) ? DCP_ACTIVE : DCP_IDLE;
  endfunction : exit_of
  task automatic issue(logic c, dcp_cmd_t cm);
    @(posedge clock);
    cke_req <= c;
    cmd_req <= cm;
    des_req <= 1'($urandom);
  endtask : issue
  // hold the level long enough for status to settle; float pins only in low power
  task automatic go(logic c, dcp_cmd_t cm, dcp_state_t exp);
    issue(c, cm);
    repeat (5) issue(c, (c || exp < DCP_PD_ACTIVE) ? DCP_CMD_NOP : DCP_CMD_OTHER);
    @(negedge clock);
    chk(power_state, exp);
  endtask : go
  task automatic summarize();
    if (failures == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  initial begin
    void'($urandom(7427));
    repeat (3) @(posedge clock);
    @(negedge clock);
    chk({settled, wr_ok, ref_en}, 8'h7);
    rst_b = 1;
    go(1, DCP_CMD_NOP, DCP_IDLE);
    repeat (4) begin
      go(0, DCP_CMD_NOP, DCP_PD_PRECHARGE);
      repeat ($urandom_range(20)) issue(0, DCP_CMD_OTHER);
      @(negedge clock);
      chk({pd, ref_en, power_state}, 8'h15);
      go(1, DCP_CMD_NOP, exit_of(DCP_PD_PRECHARGE));
    end
    issue(1, DCP_CMD_REFRESH);
    go(0, DCP_CMD_NOP, DCP_PD_PRECHARGE);
    go(1, DCP_CMD_NOP, DCP_IDLE);
    go(1, DCP_CMD_ACTIVATE, DCP_ACTIVE);
    go(0, DCP_CMD_NOP, DCP_PD_ACTIVE);
    go(1, DCP_CMD_NOP, DCP_ACTIVE);
    go(0, DCP_CMD_REFRESH, DCP_ACTIVE);
    go(1, DCP_CMD_NOP, DCP_ACTIVE);
    foreach (ops[i]) begin
      issue(1, ops[i]);
      go(0, DCP_CMD_NOP, DCP_PD_ACTIVE);
      go(1, DCP_CMD_NOP, exit_of(DCP_PD_ACTIVE));
    end
    issue(1, DCP_CMD_PRECHARGE);
    go(0, DCP_CMD_NOP, DCP_PD_PRECHARGE);
    go(1, DCP_CMD_NOP, DCP_IDLE);
    repeat (20) if (idle !== 1'b1) @(negedge clock);
    chk(idle, 1);
    go(0, DCP_CMD_REFRESH, DCP_SELF_REFRESH);
    chk({sr, odt_en}, 8'h2);
    go(1, DCP_CMD_NOP, DCP_IDLE);
    chk({settled, wr_ok}, 8'h0);
    repeat (DCP_SRX_DELAY_CYC) @(negedge clock);
    chk(settled, 1);
    repeat (DCP_WRITE_HOLD_NCK - 20) @(negedge clock);
    chk(wr_ok, 0);
    repeat (10) @(negedge clock);
    chk(wr_ok, 1);
    summarize();
  end
endmodule : dcp_cke_power_tb_top

//--- verif/dcp_ctl_model.sv
// model: memory controller driving clock-enable and command pins
`timescale 1ns/100ps
module dcp_ctl_model
  import dcp_pkg::*;
(
  // requests
  input  wire logic       clock,
  input  wire logic       cke_req,
  input  wire dcp_cmd_t   cmd_req,
  input  wire logic       des_req,
  input  wire logic [4:0] junk,
  // pins
  output logic            cke,
  output logic            cs_b,
  output logic            ras_b,
  output logic            cas_b,
  output logic            we_b,
  output logic            a10
);
  // ******************
  // command encoding
  // ******************
  logic [2:0] code_w;
  always_comb begin
    case (cmd_req)
      DCP_CMD_REFRESH:   code_w = 3'h1;
      DCP_CMD_ACTIVATE:  code_w = 3'h3;
      DCP_CMD_PRECHARGE: code_w = 3'h2;
      DCP_CMD_READ:      code_w = 3'h5;
      DCP_CMD_WRITE:     code_w = 3'h4;
      default:           code_w = 3'h7;
    endcase
  end
  initial {cke, cs_b, ras_b, cas_b, we_b, a10} = 6'h1f;
  // pins move on the falling edge so the device samples settled levels
  always @(negedge clock) begin
    cke <= cke_req;
    a10 <= junk[4];
    if (cmd_req == DCP_CMD_OTHER)
      {cs_b, ras_b, cas_b, we_b} <= junk[3:0];
    else if (des_req && cmd_req == DCP_CMD_NOP)
      {cs_b, ras_b, cas_b, we_b} <= {1'b1, junk[2:0]};
    else
      {cs_b, ras_b, cas_b, we_b} <= {1'b0, code_w};
  end
endmodule : dcp_ctl_model
